// *** verilog/acc_cal_regs.sv ***
/*
  Channel 2/3 calibration and configuration register bank on APB.
  Holds the channel 2 offset low byte and gain, the channel 3
  configuration and the channel 3 offset, and drives them to the
  filter and modulator datapath.
  Assumes a single pclk domain; the global DC-block setting comes from
  logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// RULE_01: ch2 offset low byte upper; lower reads zero
// RULE_02: ch2 gain is high word plus byte
// RULE_03: ch3 offset high word holds bits 23:8
// RULE_04: ch3 signed 10-bit phase delay, bits 15:6
// RULE_05: override bit disables ch3 DC filter only
// RULE_06: two-bit input select: pins, short, tests
// RULE_07: decode indices 15h through 1Ah
// RULE_08: writes to reserved bits are ignored
module acc_cal_regs
  import acc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ACC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] global_dc_filter_setting,
  output acc_cal_t cal,
  output acc_ch3_channel_config_t ch3_channel_config,
  output logic [3:0] ch3_dc_filter_corner,
  output acc_input_path_t ch3_input_path
);
  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic [2:0] slot;
  logic hit;
  wire logic setup_phase;
  wire logic access_phase;
  wire logic wr_access;

  acc_apb_decode u_decode (
    .paddr(paddr),
    .slot(slot),
    .hit(hit)
  );

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_access = access_phase & pwrite & hit; // RULE_07

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  logic [15:0] regq [ACC_NREG];

  for (genvar i = 0; i < ACC_NREG; i++)
  begin : g_reg
    wire logic we_i;
    assign we_i = wr_access & (slot == 3'(i)); // RULE_07
    // masked bits stay zero on write
    acc_cal_reg #(
      .RESET_VAL(ACC_RST_TAB[i]),
      .WMASK(ACC_MASK_TAB[i])
    ) u_reg ( // RULE_08
      .pclk(pclk),
      .presetn(presetn),
      .we(we_i),
      .strb(pstrb[1:0]),
      .wdata(pwdata[15:0]),
      .q(regq[i])
    );
  end

  // ----------------------------------------------------------------------
  // read path and answer
  // ----------------------------------------------------------------------
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  wire logic [15:0] rd_word;

  assign rd_word = hit ? regq[slot] : ACC_READ_PAD;
  // sample on setup so the access phase answers from flops
  assign prdata_next = setup_phase ? {ACC_READ_PAD, rd_word} : prdata_reg;
  assign pslverr_next = setup_phase ? ~hit : (access_phase ? pslverr_reg : 1'b0); // RULE_07

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg & access_phase;
  // zero wait states
  assign pready = 1'b1;

  // ----------------------------------------------------------------------
  // calibration outputs
  // ----------------------------------------------------------------------
  wire logic [15:0] ch2_ofs_lo_q;
  wire logic [15:0] ch2_gain_hi_q;
  wire logic [15:0] ch2_gain_lo_q;
  wire logic [15:0] ch3_channel_config_q;
  wire logic [15:0] ch3_ofs_hi_q;
  wire logic [15:0] ch3_ofs_lo_q;

  assign ch2_ofs_lo_q = regq[ACC_SLOT_CH2_OFS_LO];
  assign ch2_gain_hi_q = regq[ACC_SLOT_CH2_GAIN_HI];
  assign ch2_gain_lo_q = regq[ACC_SLOT_CH2_GAIN_LO];
  assign ch3_channel_config_q = regq[ACC_SLOT_CH3_CHANNEL_CONFIG];
  assign ch3_ofs_hi_q = regq[ACC_SLOT_CH3_OFS_HI];
  assign ch3_ofs_lo_q = regq[ACC_SLOT_CH3_OFS_LO];

  assign cal.ch2_offset_low = ch2_ofs_lo_q[15:8]; // RULE_01
  assign cal.ch2_gain = {ch2_gain_hi_q, ch2_gain_lo_q[15:8]}; // RULE_02
  assign cal.ch3_offset = {ch3_ofs_hi_q, ch3_ofs_lo_q[15:8]}; // RULE_03

  // ----------------------------------------------------------------------
  // channel 3 configuration
  // ----------------------------------------------------------------------
  wire acc_input_sel_t sel_field;

  assign ch3_channel_config.phase = signed'(ch3_channel_config_q[ACC_PHASE_MSB:ACC_PHASE_LSB]); // RULE_04
  assign ch3_channel_config.dc_override = ch3_channel_config_q[ACC_OVR_BIT];
  assign sel_field = acc_input_sel_t'(ch3_channel_config_q[ACC_SEL_MSB:ACC_SEL_LSB]);
  assign ch3_channel_config.sel = sel_field;

  // per-channel override forces the corner to "off"
  assign ch3_dc_filter_corner = ch3_channel_config_q[ACC_OVR_BIT] ? 4'h0 : global_dc_filter_setting; // RULE_05

  assign ch3_input_path.pins = (sel_field == ACC_IN_PINS); // RULE_06
  assign ch3_input_path.shorted = (sel_field == ACC_IN_SHORT); // RULE_06
  assign ch3_input_path.pos_test = (sel_field == ACC_IN_POS_TEST); // RULE_06
  assign ch3_input_path.neg_test = (sel_field == ACC_IN_NEG_TEST); // RULE_06

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  wire logic full_wr;
  wire logic rd_setup;

  assign full_wr = wr_access & (pstrb[1:0] == 2'h3);
  assign rd_setup = setup_phase & ~pwrite;

  AST_CH2_OFS_LOW_RSVD: assert property ( // RULE_01
    @(posedge pclk) disable iff (!presetn)
    rd_setup && hit && slot == ACC_SLOT_CH2_OFS_LO
    |=> prdata[7:0] == 8'h00 && prdata[15:8] == cal.ch2_offset_low)
    else $error("ch2 offset low register reads wrong");

  AST_CH2_GAIN_WRITE: assert property ( // RULE_02
    @(posedge pclk) disable iff (!presetn)
    full_wr && slot == ACC_SLOT_CH2_GAIN_HI
    |=> cal.ch2_gain[23:8] == $past(pwdata[15:0]) && $stable(cal.ch2_gain[7:0]))
    else $error("ch2 gain high word not updated");

  AST_CH2_GAIN_LOW_WRITE: assert property ( // RULE_02
    @(posedge pclk) disable iff (!presetn)
    full_wr && slot == ACC_SLOT_CH2_GAIN_LO
    |=> cal.ch2_gain[7:0] == $past(pwdata[15:8]) && regq[ACC_SLOT_CH2_GAIN_LO][7:0] == 8'h00)
    else $error("ch2 gain low byte not updated");

  AST_CH2_GAIN_RESET: assert property ( // RULE_02
    @(posedge pclk)
    $rose(presetn) |-> cal.ch2_gain == 24'h800000)
    else $error("ch2 gain reset value wrong");

  AST_CH3_OFS_HIGH: assert property ( // RULE_03
    @(posedge pclk) disable iff (!presetn)
    full_wr && slot == ACC_SLOT_CH3_OFS_HI
    |=> cal.ch3_offset[23:8] == $past(pwdata[15:0]))
    else $error("ch3 offset high word not updated");

  AST_CH3_PHASE: assert property ( // RULE_04
    @(posedge pclk) disable iff (!presetn)
    full_wr && slot == ACC_SLOT_CH3_CHANNEL_CONFIG
    |=> ch3_channel_config.phase == signed'($past(pwdata[15:6])) ##1 $stable(ch3_channel_config.phase) || $past(wr_access))
    else $error("ch3 phase delay not stored");

  AST_DC_OVERRIDE: assert property ( // RULE_05
    @(posedge pclk) disable iff (!presetn)
    ch3_channel_config.dc_override |-> ch3_dc_filter_corner == 4'h0)
    else $error("ch3 dc filter not disabled by override");

  AST_DC_FOLLOW: assert property ( // RULE_05
    @(posedge pclk) disable iff (!presetn)
    !ch3_channel_config.dc_override |-> ch3_dc_filter_corner == global_dc_filter_setting)
    else $error("ch3 dc filter ignores global setting");

  AST_INPUT_ONEHOT: assert property ( // RULE_06
    @(posedge pclk) disable iff (!presetn)
    $onehot(ch3_input_path) && (ch3_input_path.shorted == (ch3_channel_config_q[1:0] == 2'h1)))
    else $error("ch3 input path decode wrong");

  AST_UNMAPPED_ERR: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    setup_phase && !hit |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");

  AST_MAPPED_OK: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    setup_phase && paddr == {6'h00, ACC_IDX_CH3_OFS_LO} * 4 |=> !pslverr)
    else $error("mapped access flagged as error");

  AST_RSVD_CFG: assert property ( // RULE_08
    @(posedge pclk) disable iff (!presetn)
    full_wr && slot == ACC_SLOT_CH3_CHANNEL_CONFIG |=> ch3_channel_config_q[5:3] == 3'h0 [*2])
    else $error("reserved config bits took a write");

  AST_CH2_OFS_LOW_WRITE: assert property ( // RULE_01
    @(posedge pclk) disable iff (!presetn)
    full_wr && slot == ACC_SLOT_CH2_OFS_LO
    |=> cal.ch2_offset_low == $past(pwdata[15:8]) && regq[ACC_SLOT_CH2_OFS_LO][7:0] == 8'h00)
    else $error("ch2 offset low byte not stored");

  AST_GAIN_LANE0: assert property ( // RULE_02
    @(posedge pclk) disable iff (!presetn)
    wr_access && pstrb[1:0] == 2'h1 && slot == ACC_SLOT_CH2_GAIN_HI
    |=> cal.ch2_gain[15:8] == $past(pwdata[7:0]) && $stable(cal.ch2_gain[23:16]))
    else $error("ch2 gain byte lane write wrong");

  AST_CH3_OFS_LOW_WRITE: assert property ( // RULE_03
    @(posedge pclk) disable iff (!presetn)
    full_wr && slot == ACC_SLOT_CH3_OFS_LO
    |=> cal.ch3_offset[7:0] == $past(pwdata[15:8]) && $stable(cal.ch3_offset[23:8]))
    else $error("ch3 offset low byte not stored");

  AST_CAL_RESET: assert property ( // RULE_03
    @(posedge pclk)
    $rose(presetn) |-> cal.ch3_offset == 24'h000000 && cal.ch2_offset_low == 8'h00)
    else $error("offset reset value wrong");

  AST_CFG_RESET: assert property ( // RULE_04
    @(posedge pclk)
    $rose(presetn) |-> ch3_channel_config_q == 16'h0000 && ch3_input_path.pins)
    else $error("ch3 configuration reset value wrong");

  AST_CFG_FIELDS: assert property ( // RULE_06
    @(posedge pclk) disable iff (!presetn)
    full_wr && slot == ACC_SLOT_CH3_CHANNEL_CONFIG
    |=> ch3_channel_config.sel == acc_input_sel_t'($past(pwdata[1:0])) && ch3_channel_config.dc_override == $past(pwdata[2]))
    else $error("ch3 select or override not stored");

  AST_LOW_RSVD_ZERO: assert property ( // RULE_08
    @(posedge pclk) disable iff (!presetn)
    regq[ACC_SLOT_CH2_OFS_LO][7:0] == 8'h00 && regq[ACC_SLOT_CH2_GAIN_LO][7:0] == 8'h00
    && regq[ACC_SLOT_CH3_OFS_LO][7:0] == 8'h00 && ch3_channel_config_q[5:3] == 3'h0)
    else $error("reserved bits not zero");

  AST_STRB_NONE: assert property ( // RULE_08
    @(posedge pclk) disable iff (!presetn)
    wr_access && pstrb[1:0] == 2'h0 |=> $stable(cal) && $stable(ch3_channel_config))
    else $error("write with no lanes changed a register");

  AST_UNMAPPED_HOLD: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    access_phase && pwrite && !hit |=> $stable(cal) && $stable(ch3_channel_config))
    else $error("unmapped write changed a register");

  AST_SLVERR_ACCESS_ONLY: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    !access_phase |-> !pslverr)
    else $error("error flag outside access phase");

  AST_READ_UPPER_ZERO: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");

  // ----------------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------------
  COV_GAIN_WRITE: cover property (
    @(posedge pclk) disable iff (!presetn)
    full_wr && slot == ACC_SLOT_CH2_GAIN_HI);

  COV_CFG_READ_BACK: cover property (
    @(posedge pclk) disable iff (!presetn)
    full_wr && slot == ACC_SLOT_CH3_CHANNEL_CONFIG ##[1:4] rd_setup && hit && slot == ACC_SLOT_CH3_CHANNEL_CONFIG);

  COV_UNMAPPED: cover property (
    @(posedge pclk) disable iff (!presetn)
    access_phase && pslverr);

  COV_OVERRIDE: cover property (
    @(posedge pclk) disable iff (!presetn)
    $rose(ch3_channel_config.dc_override));

  // single byte lane write
  COV_LANE_WRITE: cover property (
    @(posedge pclk) disable iff (!presetn)
    wr_access && pstrb[1:0] == 2'h1);
endmodule : acc_cal_regs
`default_nettype wire

// *** shared/acc_pkg.sv ***
/*
  Constants and carrier types for the channel 2/3 calibration and
  configuration register bank.
  Assumes an APB slave with 32-bit data, each register one aligned word.
*/
`default_nettype none
package acc_pkg;
  // ----------------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------------
  localparam int ACC_NREG = 6;
  localparam int ACC_ADDR_W = 12;
  localparam logic [5:0] ACC_IDX_CH2_OFS_LO = 6'h15;
  localparam logic [5:0] ACC_IDX_CH2_GAIN_HI = 6'h16;
  localparam logic [5:0] ACC_IDX_CH2_GAIN_LO = 6'h17;
  localparam logic [5:0] ACC_IDX_CH3_CHANNEL_CONFIG = 6'h18;
  localparam logic [5:0] ACC_IDX_CH3_OFS_HI = 6'h19;
  localparam logic [5:0] ACC_IDX_CH3_OFS_LO = 6'h1a;
  // slot numbers inside the bank
  localparam logic [2:0] ACC_SLOT_CH2_OFS_LO = 3'h0;
  localparam logic [2:0] ACC_SLOT_CH2_GAIN_HI = 3'h1;
  localparam logic [2:0] ACC_SLOT_CH2_GAIN_LO = 3'h2;
  localparam logic [2:0] ACC_SLOT_CH3_CHANNEL_CONFIG = 3'h3;
  localparam logic [2:0] ACC_SLOT_CH3_OFS_HI = 3'h4;
  localparam logic [2:0] ACC_SLOT_CH3_OFS_LO = 3'h5;
  // ----------------------------------------------------------------------
  // reset values and writable bit masks, by slot
  // ----------------------------------------------------------------------
  localparam logic [15:0] ACC_RST_ZERO = 16'h0000;
  localparam logic [15:0] ACC_RST_GAIN_HI = 16'h8000;
  localparam logic [15:0] ACC_MASK_HIGH_BYTE = 16'hff00;
  localparam logic [15:0] ACC_MASK_FULL = 16'hffff;
  localparam logic [15:0] ACC_MASK_CFG = 16'hffc7;
  localparam logic [15:0] ACC_RST_TAB [ACC_NREG] = '{
    ACC_RST_ZERO, ACC_RST_GAIN_HI, ACC_RST_ZERO,
    ACC_RST_ZERO, ACC_RST_ZERO, ACC_RST_ZERO};
  localparam logic [15:0] ACC_MASK_TAB [ACC_NREG] = '{
    ACC_MASK_HIGH_BYTE, ACC_MASK_FULL, ACC_MASK_HIGH_BYTE,
    ACC_MASK_CFG, ACC_MASK_FULL, ACC_MASK_HIGH_BYTE};
  // ----------------------------------------------------------------------
  // configuration field positions
  // ----------------------------------------------------------------------
  localparam int ACC_PHASE_MSB = 15;
  localparam int ACC_PHASE_LSB = 6;
  localparam int ACC_RSVD_MSB = 5;
  localparam int ACC_RSVD_LSB = 3;
  localparam int ACC_OVR_BIT = 2;
  localparam int ACC_SEL_MSB = 1;
  localparam int ACC_SEL_LSB = 0;
  localparam logic [15:0] ACC_READ_PAD = 16'h0000;

  typedef enum logic [1:0] {
    ACC_IN_PINS,
    ACC_IN_SHORT,
    ACC_IN_POS_TEST,
    ACC_IN_NEG_TEST
  } acc_input_sel_t;

  typedef struct packed {
    logic signed [9:0] phase;
    logic dc_override;
    acc_input_sel_t sel;
  } acc_ch3_channel_config_t;

  typedef struct packed {
    logic pins;
    logic shorted;
    logic pos_test;
    logic neg_test;
  } acc_input_path_t;

  typedef struct packed {
    logic [7:0] ch2_offset_low;
    logic [23:0] ch2_gain;
    logic [23:0] ch3_offset;
  } acc_cal_t;
endpackage : acc_pkg
`default_nettype wire

// *** verilog/acc_apb_decode.sv ***
/*
  Address decoder of the register bank: maps an APB byte address to a
  bank slot and flags unmapped or misaligned addresses.
  Assumes word-aligned accesses; anything else is a miss.
*/
`timescale 1ns/100ps
`default_nettype none
module acc_apb_decode
  import acc_pkg::*;
(
  input wire logic [ACC_ADDR_W-1:0] paddr,
  output logic [2:0] slot,
  output logic hit
);
  // ----------------------------------------------------------------------
  // index to slot
  // ----------------------------------------------------------------------
  function automatic logic [3:0] acc_lookup(input logic [5:0] idx);
    logic [3:0] r;
    r = 4'h0;
    unique case (idx)
      ACC_IDX_CH2_OFS_LO: r = {1'b1, ACC_SLOT_CH2_OFS_LO};
      ACC_IDX_CH2_GAIN_HI: r = {1'b1, ACC_SLOT_CH2_GAIN_HI};
      ACC_IDX_CH2_GAIN_LO: r = {1'b1, ACC_SLOT_CH2_GAIN_LO};
      ACC_IDX_CH3_CHANNEL_CONFIG: r = {1'b1, ACC_SLOT_CH3_CHANNEL_CONFIG};
      ACC_IDX_CH3_OFS_HI: r = {1'b1, ACC_SLOT_CH3_OFS_HI};
      ACC_IDX_CH3_OFS_LO: r = {1'b1, ACC_SLOT_CH3_OFS_LO};
      default: r = 4'h0;
    endcase
    return r;
  endfunction : acc_lookup

  wire logic aligned;
  wire logic upper_clear;
  wire logic [3:0] found;

  assign aligned = (paddr[1:0] == 2'h0);
  assign upper_clear = (paddr[ACC_ADDR_W-1:8] == '0);
  assign found = acc_lookup(paddr[7:2]);
  assign slot = found[2:0];
  assign hit = found[3] & aligned & upper_clear;
endmodule : acc_apb_decode
`default_nettype wire

// *** verilog/acc_cal_reg.sv ***
/*
  One 16-bit register of the bank with a per-bit write mask and byte
  strobes; masked bits hold zero whatever is written.
  Assumes the caller qualifies we with a completed APB write.
*/
`timescale 1ns/100ps
`default_nettype none
module acc_cal_reg
  import acc_pkg::*;
#(
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] WMASK = 16'hffff
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [1:0] strb,
  input wire logic [15:0] wdata,
  output logic [15:0] q
);
  logic [15:0] q_reg;
  logic [15:0] q_next;
  wire logic [15:0] lane_mask;

  assign lane_mask = {{8{strb[1]}}, {8{strb[0]}}} & WMASK;
  assign q_next = we ? ((q_reg & ~lane_mask) | (wdata & lane_mask)) : q_reg;
  assign q = q_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q_reg <= RESET_VAL & WMASK;
    else
      q_reg <= q_next;
  end
endmodule : acc_cal_reg
`default_nettype wire

// *** tb/acc_cal_regs_tb.sv ***
/*
  Self-checking testbench of the channel 2/3 calibration register bank.
  Assumes a zero-wait APB slave and the package constants for masks,
  reset values and register indices.
*/
`timescale 1ns/100ps
`default_nettype none
module acc_cal_regs_tb
  import acc_pkg::*;
;
  typedef struct {logic w; logic [31:0] d; logic e;} acc_exp_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ACC_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] global_dc_filter_setting = '0;
  acc_cal_t cal;
  acc_ch3_channel_config_t ch3_channel_config;
  logic [3:0] ch3_dc_filter_corner;
  acc_input_path_t ch3_input_path;
  logic [15:0] mdl [ACC_NREG];
  acc_exp_t expq [$];
  int fails = 0;
  int checked = 0;

  always #10 pclk = ~pclk;

  acc_cal_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_dc_filter_setting(global_dc_filter_setting), .cal(cal), .ch3_channel_config(ch3_channel_config),
    .ch3_dc_filter_corner(ch3_dc_filter_corner), .ch3_input_path(ch3_input_path));

  // ----------------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  function automatic int slot_of(input logic [ACC_ADDR_W-1:0] a);
    if (a[1:0] != 2'h0 || a[11:8] != 4'h0 || a[7:2] < ACC_IDX_CH2_OFS_LO || a[7:2] > ACC_IDX_CH3_OFS_LO)
      return -1;
    return int'(a[7:2] - ACC_IDX_CH2_OFS_LO);
  endfunction : slot_of

  function automatic logic [ACC_ADDR_W-1:0] addr_of(input int s);
    return ACC_ADDR_W'((s + int'(ACC_IDX_CH2_OFS_LO)) * 4);
  endfunction : addr_of

  // ----------------------------------------------------------------------
  // apb master: notes the expected answer, then runs one transfer
  // ----------------------------------------------------------------------
  task automatic apb(input logic [ACC_ADDR_W-1:0] a, input logic w, input logic [15:0] d, input logic [3:0] s);
    int sl;
    int n;
    logic [15:0] be;
    acc_exp_t e;
    sl = slot_of(a);
    e.w = w;
    e.e = (sl < 0);
    e.d = (sl < 0) ? 32'h0 : {16'h0, mdl[sl]};
    expq.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {16'($urandom), d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk("pready_wait", 64'(n), 64'h1);
    if (n >= 20)
      end_of_test();
    be = {{8{s[1]}}, {8{s[0]}}} & ACC_MASK_TAB[sl < 0 ? 0 : sl];
    if (w && sl >= 0)
      mdl[sl] = (mdl[sl] & ~be) | (d & be);
  endtask : apb

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
  endtask : idle

  // ----------------------------------------------------------------------
  // result monitor
  // ----------------------------------------------------------------------
  always @(posedge pclk)
  begin
    acc_exp_t e;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && expq.size() > 0)
    begin
      e = expq.pop_front();
      chk("pslverr", 64'(pslverr), 64'(e.e));
      if (!e.w)
        chk("prdata", 64'(prdata), 64'(e.d));
    end
  end

  task automatic chk_outputs();
    chk("cal", 64'(cal), 64'({mdl[0][15:8], mdl[1], mdl[2][15:8], mdl[4], mdl[5][15:8]}));
    chk("cfg", 64'(ch3_channel_config), 64'({mdl[3][15:6], mdl[3][2:0]}));
    chk("corner", 64'(ch3_dc_filter_corner), 64'(mdl[3][2] ? 4'h0 : global_dc_filter_setting));
    chk("path", 64'(ch3_input_path), 64'(4'h8 >> mdl[3][1:0]));
  endtask : chk_outputs

  initial
  begin
    #60000;
    fails++;
    end_of_test();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < ACC_NREG; i++)
      mdl[i] = ACC_RST_TAB[i];
    void'($urandom(61579));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < ACC_NREG; i++)
      apb(addr_of(i), 1'b0, 16'h0, 4'h0);
    idle();
    chk("cal_rst", 64'(cal.ch2_gain), 64'h800000);
    chk_outputs();
    $display("test reset_values done");
    for (int i = 0; i < ACC_NREG; i++)
      apb(addr_of(i), 1'b1, 16'($urandom), 4'hf);
    for (int i = 0; i < ACC_NREG; i++)
      apb(addr_of(i), 1'b0, 16'h0, 4'h0);
    idle();
    chk_outputs();
    $display("test read_write done");
    apb(addr_of(1), 1'b1, 16'($urandom), 4'b0001);
    apb(addr_of(1), 1'b1, 16'($urandom), 4'b0010);
    apb(addr_of(3), 1'b1, 16'hffff, 4'b1100);
    apb(addr_of(1), 1'b0, 16'h0, 4'h0);
    apb(addr_of(3), 1'b0, 16'h0, 4'h0);
    idle();
    $display("test strobes done");
    for (int s = 0; s < 8; s++)
    begin
      global_dc_filter_setting <= 4'($urandom);
      apb(addr_of(3), 1'b1, {10'($urandom), 3'b111, 3'(s)}, 4'h3);
      apb(addr_of(3), 1'b0, 16'h0, 4'h0);
      idle();
      chk_outputs();
    end
    $display("test config_modes done");
    apb(12'h06c, 1'b1, 16'hffff, 4'hf);
    apb(12'h06c, 1'b0, 16'h0, 4'h0);
    apb(12'h059, 1'b1, 16'hffff, 4'hf);
    apb(12'h050, 1'b0, 16'h0, 4'h0);
    apb(12'h158, 1'b0, 16'h0, 4'h0);
    for (int i = 0; i < ACC_NREG; i++)
      apb(addr_of(i), 1'b0, 16'h0, 4'h0);
    idle();
    chk_outputs();
    $display("test unmapped done");
    end_of_test();
  end
endmodule : acc_cal_regs_tb
`default_nettype wire
